// ### ptb_pkg.sv
// Constants, types and register map of the protection trip bypass logic
package ptb_pkg;

  localparam int unsigned NDIV  = 4;
  localparam int unsigned NLINE = 4;
  localparam int unsigned NSRNM = 3;

  // Plant mode selector positions
  typedef enum logic [1:0] {
    MODE_SHUTDOWN,
    MODE_REFUEL,
    MODE_STARTUP,
    MODE_RUN
  } ptb_mode_t;

  // Voted parameter indices per sensor division
  localparam int unsigned P_SIV = 0;
  localparam int unsigned P_BUS = 1;
  localparam int unsigned P_LVL = 2;
  localparam int unsigned P_CND = 3;
  localparam int unsigned P_CHG = 4;
  localparam int unsigned P_SRN = 5;
  localparam int unsigned P_OTH = 6;
  localparam int unsigned NPAR  = 7;
  localparam int unsigned NFLD  = 5;

  // Field trip input bits
  localparam int unsigned F_BUS = 0;
  localparam int unsigned F_LVL = 1;
  localparam int unsigned F_CND = 2;
  localparam int unsigned F_CHG = 3;
  localparam int unsigned F_OTH = 4;

  // Shutdown trip bypass delay
  localparam longint unsigned SD_DELAY_MS  = 64'd10000;
  localparam longint unsigned CLK_KHZ      = 64'd125000;
  localparam longint unsigned SD_DELAY_CYC = SD_DELAY_MS * CLK_KHZ;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_OPBYP = 8'h04;
  localparam logic [7:0] REG_ALARM = 8'h08;
  localparam logic [7:0] REG_TRIP  = 8'h0C;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Operational bypass word fields
  localparam int unsigned OB_CHG  = 0;
  localparam int unsigned OB_SIV  = 4;
  localparam int unsigned OB_LINE = 8;
  localparam int unsigned OB_BUS  = 12;
  localparam int unsigned OB_SD   = 13;
  localparam int unsigned OB_SRN  = 14;
  localparam int unsigned OB_LVL  = 15;
  localparam int unsigned OB_CND  = 16;
  localparam int unsigned OB_ROD  = 17;

  // Alarm word fields
  localparam int unsigned AL_CHG  = 0;
  localparam int unsigned AL_SIV  = 1;
  localparam int unsigned AL_SD   = 2;
  localparam int unsigned AL_NC   = 3;
  localparam int unsigned AL_MNT  = 4;
  localparam int unsigned AL_SENS = 8;
  localparam int unsigned AL_DOS  = 12;

  // Trip word fields
  localparam int unsigned TR_DIV   = 0;
  localparam int unsigned TR_TLU   = 4;
  localparam int unsigned TR_SCRAM = 8;
  localparam int unsigned TR_MODE  = 9;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } ptb_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } ptb_axi_rsp_t;

endpackage

// ### ptb_switch_panel.sv
// Maintenance bypass switch panel with its serial link
`timescale 1ns/1ns
module ptb_switch_panel (
  // Clock
  input  wire logic       clk_i,
  // Operator requests
  input  wire logic       link_up_i,
  input  wire logic [3:0] sens_req_i,
  input  wire logic [3:0] dos_req_i,
  // Lines towards the trip system
  output logic [3:0]      sens_byp_sw_o,
  output logic [3:0]      dos_byp_sw_o,
  output logic            sens_link_ok_o,
  output logic            dos_link_ok_o
);
  initial begin
    sens_byp_sw_o = 4'h0;
    dos_byp_sw_o = 4'h0;
    sens_link_ok_o = 1'b0;
    dos_link_ok_o = 1'b0;
  end
  // Dead link leaves lines floating: show changing junk
  always @(posedge clk_i) begin
    sens_link_ok_o <= link_up_i;
    dos_link_ok_o <= link_up_i;
    sens_byp_sw_o <= link_up_i ? sens_req_i : ~sens_byp_sw_o;
    dos_byp_sw_o <= link_up_i ? dos_req_i : ~dos_byp_sw_o;
  end
endmodule

// ### ptb_trip_bypass.sv
// Bypass, interlock and voting logic of the four-division trip system
`timescale 1ns/1ns
module ptb_trip_bypass
  import ptb_pkg::*;
#(
  parameter int unsigned  N_DIV  = NDIV,
  parameter int unsigned  N_LINE = NLINE,
  parameter int unsigned  N_STARTUP_RANGE_MONITOR = NSRNM,
  parameter logic [31:0]  SD_CYC = SD_DELAY_CYC[31:0]
) (
  // Clock, reset, enable
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              ce_i,
  // Register bus
  input  wire ptb_axi_req_t                      s_axi_req_i,
  output ptb_axi_rsp_t                           s_axi_rsp_o,
  // Mode selector and operator switches
  input  wire logic [1:0]                        mode_i,
  input  wire logic [N_DIV-1:0]                  chg_byp_sw_i,
  input  wire logic [N_LINE-1:0]                 line_byp_sw_i,
  input  wire logic [N_DIV-1:0]                  noncoinc_sw_i,
  input  wire logic [N_DIV-1:0]                  nc_disable_sw_i,
  input  wire logic [N_DIV-1:0]                  sens_byp_sw_i,
  input  wire logic                              sens_link_ok_i,
  input  wire logic [N_DIV-1:0]                  dos_byp_sw_i,
  input  wire logic                              dos_link_ok_i,
  // Field trip inputs per sensor division
  input  wire logic [N_DIV-1:0]                  press_low_i,
  input  wire logic [N_DIV-1:0][N_LINE-1:0]      siv_closed_i,
  input  wire logic [N_DIV-1:0][N_STARTUP_RANGE_MONITOR-1:0]      startup_range_monitor_trip_i,
  input  wire logic [N_DIV-1:0][NFLD-1:0]        field_trip_i,
  // Trip, alarm and indication outputs
  output logic [N_DIV-1:0]                       div_trip_o,
  output logic                                   scram_o,
  output logic                                   rod_block_en_o,
  output logic [31:0]                            opbyp_o,
  output logic [31:0]                            alarm_o
);

  // Mode and maintenance bypass state
  ptb_mode_t         mode_ff;
  logic [31:0]       sd_cnt_ff;
  logic [N_DIV-1:0]  sens_byp_ff;
  logic [N_DIV-1:0]  dos_byp_ff;
  logic [N_DIV-1:0]  nxt_sens_byp;
  logic [N_DIV-1:0]  nxt_dos_byp;
  logic [31:0]       ctrl_ff;

  // Derived bypass terms
  logic              not_run;
  logic              low_mode;
  logic              sd_byp;
  logic              sd_trip;
  logic [N_DIV-1:0]  chg_byp;
  logic [N_DIV-1:0]  siv_byp;
  logic [N_DIV-1:0]  nc_trip;
  logic [N_DIV-1:0]  tlu_trip;
  logic [N_DIV-1:0]  tlu_out;
  logic [NPAR-1:0]   par_vote;
  logic [NPAR-1:0]   par [N_DIV];
  logic [31:0]       nxt_opbyp;
  logic [31:0]       nxt_alarm;
  logic [31:0]       trip_word_ff;

  // True when two or more bits are set
  function automatic logic two_or_more(input logic [N_DIV-1:0] v);
    logic [N_DIV-1:0] rest;
    rest = v & (v - 1'b1);
    return |rest;
  endfunction

  // Joystick interlock: hold the chosen division while requested and link up; with none chosen, take lowest request
  function automatic logic [N_DIV-1:0] pick(input logic [N_DIV-1:0] req,
                                            input logic [N_DIV-1:0] cur,
                                            input logic             link);
    logic [N_DIV-1:0] res;
    res = '0;
    if (!link) begin
      res = '0;
    end else if (|cur) begin
      res = (|(cur & req)) ? cur : '0;
    end else begin
      res = req & (~req + 1'b1);
    end
    return res;
  endfunction

  // Mode selector sample
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_ff <= MODE_SHUTDOWN;
    end else if (ce_i) begin
      mode_ff <= ptb_mode_t'(mode_i);
    end
  end

  assign not_run  = (mode_ff != MODE_RUN);
  assign low_mode = (mode_ff == MODE_SHUTDOWN) || (mode_ff == MODE_REFUEL);

  // Time in Shutdown; restarts on every entry
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sd_cnt_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      if (mode_ff != MODE_SHUTDOWN) begin
        sd_cnt_ff <= 32'h0000_0000;
      end else if (sd_cnt_ff < SD_CYC) begin
        sd_cnt_ff <= sd_cnt_ff + 32'h0000_0001;
      end
    end
  end

  assign sd_byp  = (mode_ff == MODE_SHUTDOWN) && (sd_cnt_ff >= SD_CYC);
  assign sd_trip = (mode_ff == MODE_SHUTDOWN) && !sd_byp;

  // Maintenance bypass interlocks
  assign nxt_sens_byp = pick(sens_byp_sw_i, sens_byp_ff, sens_link_ok_i);
  assign nxt_dos_byp  = pick(dos_byp_sw_i, dos_byp_ff, dos_link_ok_i);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sens_byp_ff <= '0;
    end else if (ce_i) begin
      sens_byp_ff <= nxt_sens_byp;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dos_byp_ff <= '0;
    end else if (ce_i) begin
      dos_byp_ff <= nxt_dos_byp;
    end
  end

  // Per-division parameter trips after operational bypasses
  genvar d;
  generate
    for (d = 0; d < N_DIV; d++) begin : g_div
      assign chg_byp[d] = chg_byp_sw_i[d] && low_mode;
      assign siv_byp[d] = not_run && press_low_i[d];
      always_comb begin
        par[d]        = '0;
        par[d][P_SIV] = |(siv_closed_i[d] & ~line_byp_sw_i) && !siv_byp[d];
        par[d][P_BUS] = field_trip_i[d][F_BUS] && !not_run;
        par[d][P_LVL] = field_trip_i[d][F_LVL] && !not_run;
        par[d][P_CND] = field_trip_i[d][F_CND] && !not_run;
        par[d][P_CHG] = field_trip_i[d][F_CHG] && !chg_byp[d];
        par[d][P_SRN] = (|startup_range_monitor_trip_i[d]) && not_run;
        par[d][P_OTH] = field_trip_i[d][F_OTH];
      end
      assign nc_trip[d] = noncoinc_sw_i[d] && not_run &&
                          !nc_disable_sw_i[d] &&
                          (|startup_range_monitor_trip_i[d]);
      assign tlu_trip[d] = (|par_vote) || nc_trip[d] || sd_trip;
      assign tlu_out[d]  = (tlu_trip[d] && !dos_byp_ff[d]) ||
                           ctrl_ff[d];
    end
  endgenerate

  // Voting per parameter, bypassed sensor division removed
  genvar p;
  generate
    for (p = 0; p < NPAR; p++) begin : g_par
      logic [N_DIV-1:0] col;
      always_comb begin
        col = '0;
        for (int s = 0; s < N_DIV; s++) begin
          col[s] = par[s][p] && !sens_byp_ff[s];
        end
      end
      assign par_vote[p] = two_or_more(col);
    end
  endgenerate

  // Indication and alarm words
  always_comb begin
    nxt_opbyp = '0;
    nxt_opbyp[OB_CHG +: N_DIV]   = chg_byp;
    nxt_opbyp[OB_SIV +: N_DIV]   = siv_byp;
    nxt_opbyp[OB_LINE +: N_LINE] = line_byp_sw_i;
    nxt_opbyp[OB_BUS]            = not_run;
    nxt_opbyp[OB_SD]             = sd_byp;
    nxt_opbyp[OB_SRN]            = !not_run;
    nxt_opbyp[OB_LVL]            = not_run;
    nxt_opbyp[OB_CND]            = not_run;
    nxt_opbyp[OB_ROD]            = not_run;
  end

  always_comb begin
    nxt_alarm = '0;
    nxt_alarm[AL_CHG] = (|chg_byp_sw_i) && !low_mode;
    nxt_alarm[AL_SIV] = |siv_byp;
    nxt_alarm[AL_SD]  = sd_byp;
    nxt_alarm[AL_NC]  = (|noncoinc_sw_i) && !not_run;
    nxt_alarm[AL_MNT] = (|sens_byp_ff) || (|dos_byp_ff);
    nxt_alarm[AL_SENS +: N_DIV] = sens_byp_ff;
    nxt_alarm[AL_DOS +: N_DIV]  = dos_byp_ff;
  end

  // Division trip outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_trip_o <= '0;
      scram_o    <= 1'b0;
    end else if (ce_i) begin
      div_trip_o <= tlu_out;
      scram_o    <= two_or_more(tlu_out);
    end
  end

  // Indication and alarm outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rod_block_en_o <= 1'b0;
      opbyp_o        <= 32'h0000_0000;
      alarm_o        <= 32'h0000_0000;
    end else if (ce_i) begin
      rod_block_en_o <= not_run;
      opbyp_o        <= nxt_opbyp;
      alarm_o        <= nxt_alarm;
    end
  end

  // Trip status word for the register bus
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trip_word_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      trip_word_ff <= {21'h00_0000, mode_ff, two_or_more(tlu_out),
                       tlu_trip, tlu_out};
    end
  end

  // AXI4-Lite slave
  logic        aw_got_ff;
  logic        w_got_ff;
  logic [7:0]  waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] rdata_ff;
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        do_write;

  assign aw_take  = ce_i && s_axi_req_i.awvalid && !aw_got_ff && !bvalid_ff;
  assign w_take   = ce_i && s_axi_req_i.wvalid && !w_got_ff && !bvalid_ff;
  assign ar_take  = ce_i && s_axi_req_i.arvalid && !rvalid_ff;
  assign do_write = ce_i && aw_got_ff && w_got_ff && !bvalid_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      waddr_ff  <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else if (ce_i) begin
      if (aw_take) begin
        aw_got_ff <= 1'b1;
        waddr_ff  <= s_axi_req_i.awaddr;
      end else if (do_write) begin
        aw_got_ff <= 1'b0;
      end
      if (w_take) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_req_i.wdata;
        wstrb_ff <= s_axi_req_i.wstrb;
      end else if (do_write) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  // Control register: manual division trips
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RESET;
    end else if (do_write && waddr_ff == REG_CTRL && wstrb_ff[0]) begin
      ctrl_ff <= {28'h000_0000, wdata_ff[3:0]};
    end
  end

  // Write response
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (ce_i) begin
      if (do_write) begin
        bvalid_ff <= 1'b1;
        unique case (waddr_ff)
          REG_CTRL, REG_OPBYP, REG_ALARM, REG_TRIP: bresp_ff <= RESP_OKAY;
          default: bresp_ff <= RESP_SLVERR;
        endcase
      end else if (s_axi_req_i.bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read data and response
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (ce_i) begin
      if (ar_take) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= RESP_OKAY;
        unique case (s_axi_req_i.araddr)
          REG_CTRL:  rdata_ff <= ctrl_ff;
          REG_OPBYP: rdata_ff <= opbyp_o;
          REG_ALARM: rdata_ff <= alarm_o;
          REG_TRIP:  rdata_ff <= trip_word_ff;
          default: begin
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_req_i.rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    s_axi_rsp_o         = '0;
    s_axi_rsp_o.awready = ce_i && !aw_got_ff && !bvalid_ff;
    s_axi_rsp_o.wready  = ce_i && !w_got_ff && !bvalid_ff;
    s_axi_rsp_o.bvalid  = bvalid_ff;
    s_axi_rsp_o.bresp   = bresp_ff;
    s_axi_rsp_o.arready = ce_i && !rvalid_ff;
    s_axi_rsp_o.rvalid  = rvalid_ff;
    s_axi_rsp_o.rresp   = rresp_ff;
    s_axi_rsp_o.rdata   = rdata_ff;
  end

endmodule

// ### ptb_trip_bypass_assertions.sv
// Port-level checker of the trip bypass logic
`timescale 1ns/1ns
module ptb_trip_bypass_assertions
  import ptb_pkg::*;
#(
  parameter int unsigned N_DIV  = NDIV,
  parameter int unsigned N_LINE = NLINE
) (
  // Clock, reset, enable
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              ce_i,
  // Selector, switches, sensors
  input wire logic [1:0]        mode_i,
  input wire logic [N_DIV-1:0]  chg_byp_sw_i,
  input wire logic [N_LINE-1:0] line_byp_sw_i,
  input wire logic [N_DIV-1:0]  noncoinc_sw_i,
  input wire logic              sens_link_ok_i,
  input wire logic [N_DIV-1:0]  press_low_i,
  // Indications
  input wire logic              rod_block_en_o,
  input wire logic [31:0]       opbyp_o,
  input wire logic [31:0]       alarm_o
);
  logic [1:0] up_ff;
  // Mode history is valid only once the pipeline refilled
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) up_ff <= 2'd0;
    else if (!ce_i) up_ff <= 2'd0;
    else if (up_ff != 2'd3) up_ff <= up_ff + 2'd1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence link_down_s;
    !sens_link_ok_i [*3];
  endsequence
  chk_chg_cancel: assert property (
    up_ff == 2'd3 && $past(mode_i, 2) >= 2'd2 |-> opbyp_o[OB_CHG +: N_DIV] == '0)
    else $error("Charging bypass kept in Startup or Run");
  chk_chg_alarm: assert property (
    up_ff == 2'd3 && $past(mode_i, 2) >= 2'd2 && |$past(chg_byp_sw_i)
    |-> alarm_o[AL_CHG]) else $error("No alarm for charging switch left");
  chk_siv_byp: assert property (
    up_ff == 2'd3 |-> opbyp_o[OB_SIV +: N_DIV] ==
    (($past(mode_i, 2) != 2'd3) ? $past(press_low_i) : '0))
    else $error("Valve closure bypass wrong");
  chk_mode_byp: assert property (
    up_ff == 2'd3 |-> {opbyp_o[OB_BUS], opbyp_o[OB_LVL], opbyp_o[OB_CND]}
    == {3{$past(mode_i, 2) != 2'd3}}) else $error("Mode bypass wrong");
  chk_srn_run: assert property (
    up_ff == 2'd3 |-> opbyp_o[OB_SRN] == ($past(mode_i, 2) == 2'd3)
    && rod_block_en_o == ($past(mode_i, 2) != 2'd3))
    else $error("Startup monitor bypass wrong");
  chk_nc_alarm: assert property (
    up_ff == 2'd3 |-> alarm_o[AL_NC] ==
    ($past(mode_i, 2) == 2'd3 && |$past(noncoinc_sw_i)))
    else $error("Non-coincident alarm wrong");
  chk_line_byp: assert property (
    up_ff == 2'd3 |-> opbyp_o[OB_LINE +: N_LINE] == $past(line_byp_sw_i))
    else $error("Steam line bypass wrong");
  chk_one_sens: assert property (
    $onehot0(alarm_o[AL_SENS +: N_DIV])) else $error("Two sensor bypasses");
  chk_one_dos: assert property (
    $onehot0(alarm_o[AL_DOS +: N_DIV])) else $error("Two divisions out");
  chk_mnt_alarm: assert property (
    |alarm_o[AL_SENS +: N_DIV] || |alarm_o[AL_DOS +: N_DIV] |-> alarm_o[AL_MNT])
    else $error("No maintenance alarm");
  chk_link_loss: assert property (
    link_down_s |-> alarm_o[AL_SENS +: N_DIV] == '0)
    else $error("Bypass kept without link");
endmodule

bind ptb_trip_bypass ptb_trip_bypass_assertions #(
  .N_DIV(N_DIV), .N_LINE(N_LINE)
) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .mode_i(mode_i),
  .chg_byp_sw_i(chg_byp_sw_i), .line_byp_sw_i(line_byp_sw_i),
  .noncoinc_sw_i(noncoinc_sw_i), .sens_link_ok_i(sens_link_ok_i),
  .press_low_i(press_low_i), .rod_block_en_o(rod_block_en_o),
  .opbyp_o(opbyp_o), .alarm_o(alarm_o)
);

// ### tb_protection_trip_bypass_logic.sv
// Self-checking bench of the protection trip bypass logic
`timescale 1ns/1ns
module tb_protection_trip_bypass_logic
  import ptb_pkg::*;
;
  typedef struct packed {
    logic [1:0]  m;
    logic [3:0]  chg;
    logic [3:0]  line;
    logic [3:0]  press;
    logic [31:0] ob;
    logic [1:0]  al;
  } ptb_row_t;
  // Shutdown bypass delay shortened to 20 cycles
  localparam logic [31:0] SDC = 32'h0000_0014;
  // Shutdown bypass bit is timed separately from the rows
  localparam logic [31:0] OBM = 32'hFFFF_DFFF;
  ptb_row_t rows [4] = '{
    '{2'd1, 4'h5, 4'h2, 4'h3, 32'h0003_9235, 2'b10},
    '{2'd2, 4'hF, 4'h0, 4'hF, 32'h0003_90F0, 2'b11},
    '{2'd3, 4'h1, 4'h8, 4'hF, 32'h0000_4800, 2'b01},
    '{2'd0, 4'hA, 4'h0, 4'h0, 32'h0003_900A, 2'b00}};
  logic            clk_i, rst_i, ce, link, slk, dlk, scram, rod;
  ptb_axi_req_t    req;
  ptb_axi_rsp_t    rsp;
  logic [1:0]      mode, resp;
  logic [3:0]      chg, line, ncs, ncd, press, sreq, dreq, sbs, dbs, div;
  logic [3:0][3:0] siv;
  logic [3:0][2:0] srn;
  logic [3:0][4:0] fld;
  logic [31:0]     opbyp, alarm, rd;
  int              failures, comparisons;

  ptb_trip_bypass #(.SD_CYC(SDC)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .s_axi_req_i(req),
    .s_axi_rsp_o(rsp), .mode_i(mode), .chg_byp_sw_i(chg),
    .line_byp_sw_i(line), .noncoinc_sw_i(ncs), .nc_disable_sw_i(ncd),
    .sens_byp_sw_i(sbs), .sens_link_ok_i(slk), .dos_byp_sw_i(dbs),
    .dos_link_ok_i(dlk), .press_low_i(press), .siv_closed_i(siv),
    .startup_range_monitor_trip_i(srn), .field_trip_i(fld), .div_trip_o(div),
    .scram_o(scram), .rod_block_en_o(rod), .opbyp_o(opbyp),
    .alarm_o(alarm));
  ptb_switch_panel u_panel (
    .clk_i(clk_i), .link_up_i(link), .sens_req_i(sreq), .dos_req_i(dreq),
    .sens_byp_sw_o(sbs), .dos_byp_sw_o(dbs), .sens_link_ok_o(slk),
    .dos_link_ok_o(dlk));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic go(input int k);
    repeat (k) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // Ready seen at negedge equals its value at the next edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk_i);
      ta = rsp.awready;
      tw = rsp.wready;
      tb = rsp.bvalid;
      resp = rsp.bresp;
      @(posedge clk_i);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
    end
    req.bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    logic ta, tr;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk_i);
      ta = rsp.arready;
      tr = rsp.rvalid;
      rd = rsp.rdata;
      resp = rsp.rresp;
      @(posedge clk_i);
      if (ta) req.arvalid <= 1'b0;
    end
    req.rready <= 1'b0;
  endtask

  task automatic results;
    $display("Comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #40000;
    failures++;
    results();
  end

  initial begin
    rst_i = 1'b1;
    req = '0;
    mode = 2'd3;
    {chg, line, ncs, ncd, press, sreq, dreq} = '0;
    siv = '0;
    srn = '0;
    fld = '0;
    link = 1'b1;
    ce = 1'b1;
    failures = 0;
    comparisons = 0;
    go(7);
    chk("opbyp in reset", 32'h0, opbyp);
    @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      mode <= rows[i].m;
      chg <= rows[i].chg;
      line <= rows[i].line;
      press <= rows[i].press;
      go(4);
      chk("opbyp", rows[i].ob, opbyp & OBM);
      chk("rod", {31'h0, rows[i].ob[OB_ROD]}, {31'h0, rod});
      chk("alarm", {30'h0, rows[i].al}, alarm & 32'h0000_0003);
    end
    chk("shutdown scram", 32'h1, {31'h0, scram});
    go(14);
    chk("early sd bypass", 32'h0, opbyp & 32'h0000_2000);
    go(8);
    chk("sd bypass", 32'h0000_2000, opbyp & 32'h0000_2000);
    chk("sd alarm", 32'h0000_0004, alarm & 32'h0000_0004);
    chk("sd scram off", 32'h0, {31'h0, scram});
    @(posedge clk_i);
    mode <= 2'd3;
    sreq <= 4'b0100;
    go(4);
    chk("sensor bypass", 32'h0000_0410, alarm & 32'h0000_0F10);
    @(posedge clk_i);
    sreq <= 4'b0101;
    dreq <= 4'b0010;
    go(4);
    chk("sensor lock", 32'h0000_0410, alarm & 32'h0000_0F10);
    @(posedge clk_i);
    link <= 1'b0;
    go(4);
    chk("link loss", 32'h0, alarm & 32'h0000_FF10);
    @(posedge clk_i);
    link <= 1'b1;
    sreq <= 4'b0001;
    dreq <= 4'b0010;
    fld[0][F_OTH] <= 1'b1;
    fld[2][F_OTH] <= 1'b1;
    go(4);
    chk("maint alarm", 32'h0000_2110, alarm & 32'h0000_FF10);
    chk("one vote", 32'h0, {27'h0, scram, div});
    @(posedge clk_i);
    fld[3][F_OTH] <= 1'b1;
    go(4);
    chk("two votes", 32'h0000_001D, {27'h0, scram, div});
    @(posedge clk_i);
    fld <= '0;
    @(posedge clk_i);
    axw(REG_CTRL, 32'h0000_0002);
    chk("ctrl wr resp", 32'h0, {30'h0, resp});
    go(3);
    chk("manual trip", 32'h0000_0002, {27'h0, scram, div});
    @(posedge clk_i);
    axr(REG_CTRL);
    chk("ctrl rd", 32'h0000_0002, rd);
    @(posedge clk_i);
    axr(8'h10);
    chk("bad rd resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    chk("bad rd data", 32'h0, rd);
    axw(REG_OPBYP, 32'hFFFF_FFFF);
    chk("ro wr resp", {30'h0, RESP_OKAY}, {30'h0, resp});
    axr(REG_OPBYP);
    chk("opbyp reg", 32'h0000_4000, rd);
    axw(REG_CTRL, 32'h0000_0000);
    dreq <= 4'h0;
    mode <= 2'd2;
    ncs <= 4'h1;
    srn[0][1] <= 1'b1;
    go(4);
    chk("nc trip", 32'h1, {28'h0, div});
    @(posedge clk_i);
    ncd <= 4'h1;
    go(4);
    chk("nc disable", 32'h0, {28'h0, div});
    @(posedge clk_i);
    ncd <= 4'h0;
    mode <= 2'd3;
    go(4);
    chk("nc in run", 32'h0, {28'h0, div});
    chk("nc alarm", 32'h0000_0008, alarm & 32'h0000_0008);
    @(posedge clk_i);
    ce <= 1'b0;
    mode <= 2'd0;
    go(4);
    chk("frozen opbyp", 32'h0000_4000, opbyp);
    chk("frozen scram", 32'h0, {31'h0, scram});
    @(posedge clk_i);
    ce <= 1'b1;
    go(4);
    chk("enable opbyp", 32'h0003_900A, opbyp);
    chk("enable scram", 32'h1, {31'h0, scram});
    results();
  end
endmodule
